/* File: logic/mws_pkg.sv */
package mws_pkg;
    localparam int unsigned ADDR_W = 22;
    localparam int unsigned WS_W = 5;
    // byte addresses of the configuration registers
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_FLASH_WS = 12'h004;
    localparam logic [11:0] REG_OTP_WS = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    // ctrl fields: bit per region protected
    localparam int unsigned CTRL_PROT_F1 = 0;
    localparam int unsigned CTRL_PROT_F2 = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    // flash ws fields: paged [3:0], random [11:8]
    localparam int unsigned FWS_PAGED_LSB = 0;
    localparam int unsigned FWS_RANDOM_LSB = 8;
    localparam logic [3:0] FWS_PAGED_RESET = 4'hF;
    localparam logic [3:0] FWS_RANDOM_RESET = 4'hF;
    localparam logic [3:0] OTP_WS_RESET = 4'hF;
    localparam logic [3:0] RANDOM_MIN = 4'h1;
    localparam logic [3:0] OTP_MIN = 4'h1;
    localparam logic [WS_W-1:0] READ_WS_PF = 5'h02;
    localparam logic [WS_W-1:0] PASSWORD_WS = 5'h10;
    // region bases and ends (word addresses)
    localparam logic [ADDR_W-1:0] LOWRAM_LO = 22'h000000;
    localparam logic [ADDR_W-1:0] LOWRAM_HI = 22'h0007FF;
    localparam logic [ADDR_W-1:0] PF0_LO = 22'h000800;
    localparam logic [ADDR_W-1:0] PF0_HI = 22'h0013FF;
    localparam logic [ADDR_W-1:0] PF3_LO = 22'h005000;
    localparam logic [ADDR_W-1:0] PF3_HI = 22'h005FFF;
    localparam logic [ADDR_W-1:0] PF1_LO = 22'h006000;
    localparam logic [ADDR_W-1:0] PF1_HI = 22'h006FFF;
    localparam logic [ADDR_W-1:0] PF2_LO = 22'h007000;
    localparam logic [ADDR_W-1:0] PF2_HI = 22'h007FFF;
    localparam logic [ADDR_W-1:0] LRAM_LO = 22'h008000;
    localparam logic [ADDR_W-1:0] LRAM_HI = 22'h00FFFF;
    localparam logic [ADDR_W-1:0] OTP_LO = 22'h3D7800;
    localparam logic [ADDR_W-1:0] OTP_HI = 22'h3D7BFF;
    localparam logic [ADDR_W-1:0] FLASH_LO = 22'h3D8000;
    localparam logic [ADDR_W-1:0] FLASH_HI = 22'h3F7FF7;
    localparam logic [ADDR_W-1:0] PWD_LO = 22'h3F7FF8;
    localparam logic [ADDR_W-1:0] PWD_HI = 22'h3F7FFF;
    localparam logic [ADDR_W-1:0] ROM_LO = 22'h3F8000;
    localparam logic [ADDR_W-1:0] ROM_HI = 22'h3FFFFF;
    typedef enum logic [3:0] {
        MWS_R_NONE = 4'h0, MWS_R_LRAM = 4'h1, MWS_R_PF0 = 4'h2, MWS_R_PF1 = 4'h3,
        MWS_R_PF2 = 4'h4, MWS_R_PF3 = 4'h5, MWS_R_SHARED = 4'h6, MWS_R_OTP = 4'h7,
        MWS_R_FLASH = 4'h8, MWS_R_PWD = 4'h9, MWS_R_ROM = 4'hA
    } mws_region_e;
    typedef enum logic [1:0] {
        MWS_IDLE = 2'b00, MWS_WAIT = 2'b01, MWS_HOLD = 2'b11
    } mws_state_e;
endpackage

/* File: logic/mws_decode.sv */
`timescale 1ns/1ps
module mws_decode (
    input wire logic [mws_pkg::ADDR_W-1:0] addr,
    output mws_pkg::mws_region_e region
);
    always_comb begin
        region = mws_pkg::MWS_R_NONE;
        if (addr <= mws_pkg::LOWRAM_HI) begin
            region = mws_pkg::MWS_R_LRAM;
        end else if (addr >= mws_pkg::PF0_LO && addr <= mws_pkg::PF0_HI) begin
            region = mws_pkg::MWS_R_PF0;
        end else if (addr >= mws_pkg::PF3_LO && addr <= mws_pkg::PF3_HI) begin
            region = mws_pkg::MWS_R_PF3;
        end else if (addr >= mws_pkg::PF1_LO && addr <= mws_pkg::PF1_HI) begin
            region = mws_pkg::MWS_R_PF1;
        end else if (addr >= mws_pkg::PF2_LO && addr <= mws_pkg::PF2_HI) begin
            region = mws_pkg::MWS_R_PF2;
        end else if (addr >= mws_pkg::LRAM_LO && addr <= mws_pkg::LRAM_HI) begin
            region = mws_pkg::MWS_R_SHARED;
        end else if (addr >= mws_pkg::OTP_LO && addr <= mws_pkg::OTP_HI) begin
            region = mws_pkg::MWS_R_OTP;
        end else if (addr >= mws_pkg::FLASH_LO && addr <= mws_pkg::FLASH_HI) begin
            region = mws_pkg::MWS_R_FLASH;
        end else if (addr >= mws_pkg::PWD_LO && addr <= mws_pkg::PWD_HI) begin
            region = mws_pkg::MWS_R_PWD;
        end else if (addr >= mws_pkg::ROM_LO) begin
            region = mws_pkg::MWS_R_ROM;
        end
    end
endmodule // mws_decode

/* File: logic/mws_top.sv */
`timescale 1ns/1ps
module mws_top (
    input wire logic clk,
    input wire logic rst,
    // ahb-lite configuration slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // cpu side
    input wire logic cpu_req,
    input wire logic cpu_write,
    input wire logic [mws_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic cpu_paged,
    output logic cpu_stall,
    output logic cpu_done,
    // memory / peripheral side
    output logic mem_en,
    output logic mem_write,
    output logic [mws_pkg::ADDR_W-1:0] mem_addr,
    input wire logic periph_ready,
    input wire logic contend
);
    mws_pkg::mws_region_e region;
    mws_pkg::mws_state_e st_q, st_d;
    logic [mws_pkg::WS_W-1:0] cnt_q, cnt_d;
    logic [1:0] prot_q, prot_d;
    logic [3:0] paged_q, paged_d, random_q, random_d, otp_q, otp_d;
    logic last_f1_wr_q, last_f1_wr_d;
    logic stall_q, stall_d, done_q, done_d, en_q, en_d, wr_q, wr_d;
    logic [mws_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [mws_pkg::ADDR_W-1:0] pend_addr_q, pend_addr_d;
    logic pend_wr_q, pend_wr_d;
    logic busy_q, busy_d;
    mws_pkg::mws_region_e cur_q, cur_d;
    logic [mws_pkg::WS_W-1:0] ws;
    logic extendable, is_prot;
    logic [31:0] rdata_q, rdata_d;
    logic ph_q, ph_d, phw_q, phw_d;
    logic [11:0] pha_q, pha_d;
    logic [3:0] rnd_eff, otp_eff;

    mws_decode u_dec (
        .addr(cpu_addr),
        .region(region)
    );

    // clamp programmed values to legal floors
    always_comb begin
        otp_eff = (otp_q < mws_pkg::OTP_MIN) ? mws_pkg::OTP_MIN : otp_q;
        rnd_eff = (random_q < mws_pkg::RANDOM_MIN) ? mws_pkg::RANDOM_MIN : random_q;
        if (rnd_eff < paged_q) begin
            rnd_eff = paged_q;
        end
    end

    always_comb begin
        ws = '0;
        extendable = 1'b0;
        is_prot = 1'b0;
        unique case (region)
            mws_pkg::MWS_R_PF1: begin
                ws = cpu_write ? '0 : mws_pkg::READ_WS_PF;
                extendable = 1'b1;
                is_prot = prot_q[mws_pkg::CTRL_PROT_F1];
                if (cpu_write && last_f1_wr_q) begin
                    ws = 5'h01;
                end
            end
            mws_pkg::MWS_R_PF2: begin
                ws = cpu_write ? '0 : mws_pkg::READ_WS_PF;
                is_prot = prot_q[mws_pkg::CTRL_PROT_F2];
            end
            mws_pkg::MWS_R_PF3: begin
                ws = cpu_write ? '0 : mws_pkg::READ_WS_PF;
                extendable = 1'b1;
            end
            mws_pkg::MWS_R_OTP: ws = {1'b0, otp_eff};
            mws_pkg::MWS_R_FLASH: ws = {1'b0, cpu_paged ? paged_q : rnd_eff};
            mws_pkg::MWS_R_PWD: ws = mws_pkg::PASSWORD_WS;
            mws_pkg::MWS_R_LRAM, mws_pkg::MWS_R_PF0, mws_pkg::MWS_R_SHARED,
            mws_pkg::MWS_R_ROM, mws_pkg::MWS_R_NONE: ws = '0;
            default: ws = '0;
        endcase
    end

    // access sequencer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        stall_d = 1'b0;
        done_d = 1'b0;
        en_d = 1'b0;
        wr_d = wr_q;
        addr_d = addr_q;
        cur_d = cur_q;
        last_f1_wr_d = last_f1_wr_q;
        pend_addr_d = pend_addr_q;
        pend_wr_d = pend_wr_q;
        busy_d = busy_q;
        unique case (st_q)
            mws_pkg::MWS_IDLE: begin
                if (cpu_req) begin
                    en_d = 1'b1;
                    wr_d = cpu_write;
                    addr_d = cpu_addr;
                    cur_d = region;
                    last_f1_wr_d = cpu_write && region == mws_pkg::MWS_R_PF1;
                    // reads of a protected region are not let past a pending protected write
                    if (is_prot && busy_q && !cpu_write) begin
                        cnt_d = 5'h01;
                        st_d = mws_pkg::MWS_HOLD;
                        stall_d = 1'b1;
                    end else if (ws != '0 || (region == mws_pkg::MWS_R_PF3 && contend) ||
                            (region == mws_pkg::MWS_R_SHARED && contend)) begin
                        cnt_d = ws;
                        st_d = mws_pkg::MWS_WAIT;
                        stall_d = 1'b1;
                    end else begin
                        done_d = 1'b1;
                    end
                    busy_d = is_prot && cpu_write;
                    pend_addr_d = cpu_addr;
                    pend_wr_d = cpu_write;
                end else begin
                    busy_d = 1'b0;
                    last_f1_wr_d = 1'b0;
                end
            end
            mws_pkg::MWS_HOLD: begin
                en_d = 1'b1;
                stall_d = 1'b1;
                busy_d = 1'b0;
                st_d = mws_pkg::MWS_WAIT;
                cnt_d = ws;
            end
            mws_pkg::MWS_WAIT: begin
                en_d = 1'b1;
                stall_d = 1'b1;
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 5'h01;
                end else if ((extendable && !periph_ready) || contend) begin
                    cnt_d = '0;
                end else begin
                    stall_d = 1'b0;
                    done_d = 1'b1;
                    en_d = 1'b0;
                    st_d = mws_pkg::MWS_IDLE;
                end
            end
            default: st_d = mws_pkg::MWS_IDLE;
        endcase
    end

    // ahb-lite register slave, zero-wait, always okay
    always_comb begin
        ph_d = hsel && hready && htrans[1];
        phw_d = hwrite;
        pha_d = haddr[11:0];
        prot_d = prot_q;
        paged_d = paged_q;
        random_d = random_q;
        otp_d = otp_q;
        rdata_d = rdata_q;
        if (ph_q && phw_q) begin
            unique case (pha_q)
                mws_pkg::REG_CTRL: prot_d = hwdata[1:0];
                mws_pkg::REG_FLASH_WS: begin
                    paged_d = hwdata[mws_pkg::FWS_PAGED_LSB +: 4];
                    random_d = hwdata[mws_pkg::FWS_RANDOM_LSB +: 4];
                end
                mws_pkg::REG_OTP_WS: otp_d = hwdata[3:0];
                default: ;
            endcase
        end
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[11:0])
                mws_pkg::REG_CTRL: rdata_d = {30'h0, prot_q};
                mws_pkg::REG_FLASH_WS: rdata_d = {20'h0, rnd_eff, 4'h0, paged_q};
                mws_pkg::REG_OTP_WS: rdata_d = {28'h0, otp_eff};
                mws_pkg::REG_STATUS: rdata_d = {24'h0, 3'h0, cur_q, st_q == mws_pkg::MWS_IDLE};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= mws_pkg::MWS_IDLE;
            cnt_q <= '0;
            stall_q <= 1'b0;
            done_q <= 1'b0;
            en_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= '0;
            cur_q <= mws_pkg::MWS_R_NONE;
            last_f1_wr_q <= 1'b0;
            pend_addr_q <= '0;
            pend_wr_q <= 1'b0;
            busy_q <= 1'b0;
            prot_q <= mws_pkg::CTRL_RESET;
            paged_q <= mws_pkg::FWS_PAGED_RESET;
            random_q <= mws_pkg::FWS_RANDOM_RESET;
            otp_q <= mws_pkg::OTP_WS_RESET;
            rdata_q <= 32'h0;
            ph_q <= 1'b0;
            phw_q <= 1'b0;
            pha_q <= 12'h000;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            stall_q <= stall_d;
            done_q <= done_d;
            en_q <= en_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            cur_q <= cur_d;
            last_f1_wr_q <= last_f1_wr_d;
            pend_addr_q <= pend_addr_d;
            pend_wr_q <= pend_wr_d;
            busy_q <= busy_d;
            prot_q <= prot_d;
            paged_q <= paged_d;
            random_q <= random_d;
            otp_q <= otp_d;
            rdata_q <= rdata_d;
            ph_q <= ph_d;
            phw_q <= phw_d;
            pha_q <= pha_d;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cpu_stall = stall_q;
    assign cpu_done = done_q;
    assign mem_en = en_q;
    assign mem_write = wr_q;
    assign mem_addr = addr_q;
endmodule // mws_top

/* File: verification/mws_properties.sv */
`timescale 1ns/1ps
module mws_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic cpu_stall,
    input wire logic cpu_done,
    input wire logic mem_en,
    input wire logic mem_write,
    input wire logic [mws_pkg::ADDR_W-1:0] mem_addr,
    input wire logic contend
);
    logic [5:0] run_q;
    logic [5:0] run_d;
    logic [mws_pkg::ADDR_W-1:0] la_q;
    logic lw_q;
    logic ended;
    // run_q is the length of the stall that just ended, read when ended is high
    always_comb run_d = cpu_stall ? run_q + 6'h01 : 6'h00;
    assign ended = !cpu_stall && run_q != 6'h00;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= 6'h00;
            la_q <= '0;
            lw_q <= 1'b0;
        end else begin
            run_q <= run_d;
            la_q <= mem_addr;
            lw_q <= mem_write;
        end
    end
    function automatic logic in_r(input logic [21:0] a, input logic [21:0] lo, input logic [21:0] hi);
        return a >= lo && a <= hi;
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    stall_holds_access_a: assert property (cpu_stall |-> mem_en)
        else $error("stall without a held access");
    stall_ends_done_a: assert property ($fell(cpu_stall) |-> ##[0:1] cpu_done)
        else $error("held access ended without completion");
    ram_zero_wait_a: assert property (mem_en && in_r(mem_addr, mws_pkg::LRAM_LO, mws_pkg::LRAM_HI)
        && !contend && !$past(contend) |-> !cpu_stall) else $error("shared ram stalled without contention");
    pwd_wait_a: assert property (ended && !lw_q && in_r(la_q, mws_pkg::PWD_LO, mws_pkg::PWD_HI)
        |-> run_q == 6'd17) else $error("password read not held seventeen cycles");
    frame2_fixed_a: assert property (ended && !lw_q && in_r(la_q, mws_pkg::PF2_LO, mws_pkg::PF2_HI)
        |-> run_q == 6'd3 || run_q == 6'd4) else $error("frame two read timing not fixed");
    frame2_write_a: assert property (mem_en && mem_write && in_r(mem_addr, mws_pkg::PF2_LO, mws_pkg::PF2_HI)
        |-> !cpu_stall) else $error("frame two write stalled");
    frame1_read_a: assert property (ended && !lw_q && in_r(la_q, mws_pkg::PF1_LO, mws_pkg::PF1_HI)
        |-> run_q >= 6'd3) else $error("frame one read too short");
    otp_min_a: assert property (ended && in_r(la_q, mws_pkg::OTP_LO, mws_pkg::OTP_HI)
        |-> run_q >= 6'd2) else $error("one-time area below one wait");
    cover property (ended && in_r(la_q, mws_pkg::PWD_LO, mws_pkg::PWD_HI));
    cover property (ended && in_r(la_q, mws_pkg::PF1_LO, mws_pkg::PF1_HI) && run_q > 6'd4);
    cover property ($rose(cpu_done));
endmodule // mws_checker
bind mws_top mws_checker u_mws_checker (
    .clk(clk),
    .rst(rst),
    .cpu_stall(cpu_stall),
    .cpu_done(cpu_done),
    .mem_en(mem_en),
    .mem_write(mem_write),
    .mem_addr(mem_addr),
    .contend(contend)
);

/* File: verification/mws_periph_model.sv */
`timescale 1ns/1ps
module mws_periph_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_en,
    input wire logic [3:0] slow,
    output logic periph_ready
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic en_q;
    logic first;
    // ready withheld for slow cycles from each rise of mem_en, so an access taken right after a zero-wait one sees only the rest of that count
    assign first = mem_en && !en_q;
    always_comb cnt_d = first ? slow : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
    assign periph_ready = !(mem_en && (first ? slow != 4'h0 : cnt_q > 4'h1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            en_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            en_q <= mem_en;
        end
    end
endmodule // mws_periph_model

/* File: verification/tb_memory_wait_state_and_access_order.sv */
`timescale 1ns/1ps
module tb_memory_wait_state_and_access_order;
    typedef struct packed {logic w; logic [21:0] a; logic p; logic [5:0] n;} mws_row_s;
    logic clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, cpu_stall, cpu_done;
    logic cpu_req = 1'b0, cpu_write = 1'b0, cpu_paged = 1'b0, contend = 1'b0, mem_en, mem_write, ready;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [21:0] cpu_addr = '0, mem_addr;
    logic [3:0] slow = 4'h0;
    logic [5:0] n;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    mws_row_s rows [15] = '{'{1'b0, 22'h000100, 1'b0, 6'd0}, '{1'b1, 22'h008000, 1'b0, 6'd0},
        '{1'b1, 22'h000800, 1'b0, 6'd0}, '{1'b1, 22'h006000, 1'b0, 6'd0}, '{1'b0, 22'h008000, 1'b0, 6'd0},
        '{1'b0, 22'h006000, 1'b0, 6'd3}, '{1'b0, 22'h007000, 1'b0, 6'd3}, '{1'b0, 22'h005000, 1'b0, 6'd3},
        '{1'b1, 22'h005000, 1'b0, 6'd0}, '{1'b1, 22'h007000, 1'b0, 6'd0}, '{1'b0, 22'h3F8000, 1'b0, 6'd0},
        '{1'b0, 22'h3F7FF8, 1'b0, 6'd17}, '{1'b0, 22'h3E8000, 1'b0, 6'd16}, '{1'b0, 22'h3E8000, 1'b1, 6'd16},
        '{1'b0, 22'h3D7800, 1'b0, 6'd16}};
    mws_top dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_paged(cpu_paged),
        .cpu_stall(cpu_stall), .cpu_done(cpu_done), .mem_en(mem_en), .mem_write(mem_write),
        .mem_addr(mem_addr), .periph_ready(ready), .contend(contend));
    mws_periph_model peer_u (.clk(clk), .rst(rst), .mem_en(mem_en), .slow(slow), .periph_ready(ready));
    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
    task automatic reg_chk(input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(r, e);
        chk({30'h0, hresp, hreadyout}, 32'h1);
    endtask
    task automatic count_hold;
        n = 6'h00;
        forever begin
            #1;
            if (cpu_stall === 1'b1) n = n + 6'h01;
            if (cpu_done === 1'b1) break;
            @(posedge clk);
        end
    endtask
    // counts held cycles; paged stays put until the next access
    task automatic acc(input logic w, input logic [21:0] a, input logic p);
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_write <= w;
        cpu_addr <= a;
        cpu_paged <= p;
        @(posedge clk);
        cpu_req <= 1'b0;
        count_hold();
    endtask
    // second access taken on the edge right after the first, no idle gap
    task automatic pair_chk(input logic w1, input logic [21:0] a1, input logic w2, input logic [21:0] a2,
            input logic [5:0] e);
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_write <= w1;
        cpu_addr <= a1;
        cpu_paged <= 1'b0;
        @(posedge clk);
        cpu_write <= w2;
        cpu_addr <= a2;
        @(posedge clk);
        cpu_req <= 1'b0;
        count_hold();
        chk({26'h0, n}, {26'h0, e});
    endtask
    task automatic acc_chk(input logic w, input logic [21:0] a, input logic p, input logic [5:0] e);
        acc(w, a, p);
        chk({26'h0, n}, {26'h0, e});
    endtask
    task automatic acc_min(input logic [21:0] a, input logic [5:0] e);
        acc(1'b0, a, 1'b0);
        chk({31'h0, n > e}, 32'h1);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        forever @(posedge clk) begin
            cycles++;
            if (cycles > 4000) begin
                miscompares++;
                close_out;
            end
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) acc_chk(rows[i].w, rows[i].a, rows[i].p, rows[i].n);
        reg_chk(mws_pkg::REG_CTRL, 32'h3);
        reg_chk(mws_pkg::REG_FLASH_WS, 32'hF0F);
        reg_chk(mws_pkg::REG_OTP_WS, 32'hF);
        reg_chk(12'h010, 32'h0);
        acc_chk(1'b1, 22'h006000, 1'b0, 6'd0);
        pair_chk(1'b1, 22'h006000, 1'b1, 22'h006004, 6'd2);
        pair_chk(1'b1, 22'h006004, 1'b0, 22'h006008, 6'd4);
        ahb(1'b1, mws_pkg::REG_CTRL, 32'h0);
        acc_chk(1'b1, 22'h006000, 1'b0, 6'd0);
        pair_chk(1'b1, 22'h006004, 1'b0, 22'h006008, 6'd3);
        ahb(1'b1, mws_pkg::REG_CTRL, 32'h3);
        ahb(1'b1, mws_pkg::REG_FLASH_WS, 32'h2);
        reg_chk(mws_pkg::REG_FLASH_WS, 32'h202);
        acc_chk(1'b0, 22'h3E8000, 1'b1, 6'd3);
        acc_chk(1'b0, 22'h3E8000, 1'b0, 6'd3);
        ahb(1'b1, mws_pkg::REG_FLASH_WS, 32'h100);
        acc_chk(1'b0, 22'h3E8000, 1'b1, 6'd0);
        acc_chk(1'b0, 22'h3E8000, 1'b0, 6'd2);
        acc_chk(1'b0, 22'h3F7FFC, 1'b0, 6'd17);
        ahb(1'b1, mws_pkg::REG_OTP_WS, 32'h0);
        reg_chk(mws_pkg::REG_OTP_WS, 32'h1);
        acc_chk(1'b0, 22'h3D7800, 1'b0, 6'd2);
        slow <= 4'h8;
        acc_min(22'h006000, 6'd3);
        acc_min(22'h005000, 6'd3);
        acc_chk(1'b0, 22'h007000, 1'b0, 6'd3);
        slow <= 4'h0;
        // contention is released after a while, else the held access never ends
        contend <= 1'b1;
        fork
            begin
                repeat (8) @(posedge clk);
                contend <= 1'b0;
            end
            acc_min(22'h005000, 6'd3);
        join
        contend <= 1'b1;
        fork
            begin
                repeat (8) @(posedge clk);
                contend <= 1'b0;
            end
            acc_min(22'h008000, 6'd0);
        join
        acc_chk(1'b0, 22'h008000, 1'b0, 6'd0);
        ahb(1'b1, mws_pkg::REG_CTRL, 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reg_chk(mws_pkg::REG_CTRL, 32'h3);
        reg_chk(mws_pkg::REG_FLASH_WS, 32'hF0F);
        reg_chk(mws_pkg::REG_STATUS, 32'h1);
        close_out;
    end
endmodule // tb_memory_wait_state_and_access_order
